// File: include/ips_pkg.sv
`default_nettype none
package ips_pkg;
    // Register index of the priority register on the plain register port
    localparam logic [7:0] PRIO_ADDR = 8'h00;
    // Status register reporting the active service levels
    localparam logic [7:0] STAT_ADDR = 8'h01;
    localparam int NUM_SRC = 5;
    localparam int BIT_EXT_A = 0;
    localparam int BIT_TIMER_A = 1;
    localparam int BIT_EXT_B = 2;
    localparam int BIT_TIMER_B = 3;
    localparam int BIT_SERIAL = 4;
    localparam logic [2:0] UNUSED_READ = 3'h4;
    localparam logic [4:0] PRIO_RESET = 5'h00;
    localparam logic [2:0] NO_SRC = 3'h7;
endpackage
`default_nettype wire

// File: verif/ips_core_model.sv
`default_nettype none
module ips_core_model (
    input wire logic mclk,
    input wire logic en,
    input wire logic irq_req,
    output logic irq_ack = 1'b0,
    output logic irq_return = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles a routine runs before it returns; a preempting routine pauses the one below
    localparam int SVC_LEN = 4;
    int left [2] = '{0, 0};
    int depth = 0;
    always @(posedge mclk) begin
        irq_ack <= en && irq_req && !irq_ack;
        irq_return <= 1'b0;
        // An ack only opens a routine if the offer still stood when it was seen
        if (irq_ack && irq_req && depth < 2) begin
            left[depth] <= SVC_LEN;
            depth <= depth + 1;
        end else if (depth > 0 && !irq_return) begin
            if (left[depth - 1] == 1) begin
                irq_return <= 1'b1;
                depth <= depth - 1;
            end else begin
                left[depth - 1] <= left[depth - 1] - 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [4:0] irq_pending = 5'h00, sel, pr = 5'h00, m;
    logic irq_ack, irq_return, irq_req, irq_src_high;
    logic [2:0] irq_src;
    logic [31:0] rnd = 32'h4ac28759;
    int n_fail = 0, checks = 0, e;
    logic lo = 1'b0, hi = 1'b0, er = 1'b0, eh = 1'b0, ak = 1'b0;
    logic [2:0] es = 3'h7;
    logic [1:0] st = 2'b00;
    always #5 mclk = ~mclk;
    ips_top u_ips_top (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_pending(irq_pending), .irq_ack(irq_ack), .irq_return(irq_return),
        .irq_req(irq_req), .irq_src(irq_src), .irq_src_high(irq_src_high),
        .serial_irq_priority_sel(sel[4]), .timer_b_irq_priority_sel(sel[3]),
        .ext_irq_b_priority_sel(sel[2]), .timer_a_irq_priority_sel(sel[1]),
        .ext_irq_a_priority_sel(sel[0]));
    ips_core_model u_ips_core_model (.mclk(mclk), .en(en), .irq_req(irq_req),
        .irq_ack(irq_ack), .irq_return(irq_return));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic finish_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        rd(ips_pkg::PRIO_ADDR, 8'h80);
        for (int i = 0; i < 24; i++) begin
            rnd = xs(rnd);
            wr(i % 3 == 2 ? 8'h42 : ips_pkg::PRIO_ADDR, rnd[7:0]);
            if (i % 3 != 2) pr = rnd[4:0];
            rd(ips_pkg::PRIO_ADDR, {ips_pkg::UNUSED_READ, pr});
            check({3'h0, sel}, {3'h0, pr});
            rd(8'h42, 8'h00);
        end
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            rnd = xs(rnd);
            wr(ips_pkg::PRIO_ADDR, rnd[7:0]);
            pr = rnd[4:0];
            irq_pending <= rnd[12:8];
            repeat (2) @(posedge mclk);
            #1 m = (irq_pending & pr) != 0 ? irq_pending & pr : irq_pending;
            e = 7;
            for (int j = 4; j >= 0; j--) if (m[j]) e = j;
            check({3'h0, irq_req, irq_src_high, irq_src},
                {3'h0, m != 0, (irq_pending & pr) != 0, 3'(e)});
        end
        $display("test arbitration done");
        @(posedge mclk);
        irq_pending <= 5'h00;
        repeat (2) @(posedge mclk);
        en <= 1'b1;
        reg_rd <= 1'b1;
        reg_addr <= ips_pkg::STAT_ADDR;
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk);
            rnd = xs(rnd);
            irq_pending <= rnd[4:0];
            #1 check({3'h0, irq_req, irq_src_high, irq_src}, {3'h0, er, eh, es});
            check(reg_rdata, {6'h00, st});
            st = {hi, lo};
            ak = irq_ack && er;
            if (irq_return) begin
                if (hi) begin
                    hi = 1'b0;
                end else begin
                    lo = 1'b0;
                end
            end
            if (ak) begin
                if (eh) begin
                    hi = 1'b1;
                end else begin
                    lo = 1'b1;
                end
            end
            m = irq_pending & pr;
            eh = !ak && !hi && m != 0;
            if (!eh) m = !ak && !hi && !lo ? irq_pending & ~pr : 5'h00;
            er = m != 0;
            es = 3'h7;
            for (int j = 4; j >= 0; j--) if (m[j]) es = 3'(j);
        end
        @(posedge mclk);
        reg_rd <= 1'b0;
        $display("test nesting done");
        finish_test;
    end
endmodule
`default_nettype wire

// File: verilog/ips_pick.sv
`default_nettype none
// Fixed-order pick of the lowest-numbered set request
module ips_pick #(
    parameter int N = 5
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [2:0] idx
);
    always_comb begin
        found = 1'b0;
        idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule
`default_nettype wire

// File: verilog/ips_top.sv
`default_nettype none
// Overview of operation
// - Bit 4 sets serial port priority
// - Bit 3 sets second timer priority
// - Bit 2 sets second external input priority
// - Bit 1 sets first timer priority
// - Bit 0 sets first external input priority
// - Upper three bits read 100, writes ignored
module ips_top (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [4:0] irq_pending,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic irq_req,
    output logic [2:0] irq_src,
    output logic irq_src_high,
    output logic serial_irq_priority_sel,
    output logic timer_b_irq_priority_sel,
    output logic ext_irq_b_priority_sel,
    output logic timer_a_irq_priority_sel,
    output logic ext_irq_a_priority_sel
);
    logic [4:0] prio;
    logic [4:0] next_prio;
    logic [7:0] next_rdata;
    logic in_low, in_high, next_in_low, next_in_high;
    logic next_req, next_src_high;
    logic [2:0] next_src;
    logic hi_found, lo_found;
    logic [2:0] hi_idx, lo_idx;

    // Register port: only the five low bits hold state
    always_comb begin
        next_prio = prio;
        if (reg_wr && reg_addr == ips_pkg::PRIO_ADDR) begin
            next_prio = reg_wdata[4:0];
        end
        next_rdata = 8'h00;
        if (reg_rd && reg_addr == ips_pkg::PRIO_ADDR) begin
            next_rdata = {ips_pkg::UNUSED_READ, prio};
        end else if (reg_rd && reg_addr == ips_pkg::STAT_ADDR) begin
            next_rdata = {6'h00, in_high, in_low};
        end
    end

    ips_pick #(.N(ips_pkg::NUM_SRC)) u_hi (
        .req(irq_pending & prio),
        .found(hi_found),
        .idx(hi_idx)
    );
    ips_pick #(.N(ips_pkg::NUM_SRC)) u_lo (
        .req(irq_pending & ~prio),
        .found(lo_found),
        .idx(lo_idx)
    );

    // Nesting: one low and one high service may be live at a time
    always_comb begin
        next_in_low = in_low;
        next_in_high = in_high;
        if (irq_return) begin
            if (in_high) begin
                next_in_high = 1'b0;
            end else begin
                next_in_low = 1'b0;
            end
        end
        if (irq_ack && irq_req) begin
            if (irq_src_high) begin
                next_in_high = 1'b1;
            end else begin
                next_in_low = 1'b1;
            end
        end
        next_req = 1'b0;
        next_src = ips_pkg::NO_SRC;
        next_src_high = 1'b0;
        // Request drops the cycle after an ack so a served source is not re-offered
        if (!(irq_ack && irq_req) && !next_in_high) begin
            if (hi_found) begin
                next_req = 1'b1;
                next_src = hi_idx;
                next_src_high = 1'b1;
            end else if (lo_found && !next_in_low) begin
                next_req = 1'b1;
                next_src = lo_idx;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            prio <= ips_pkg::PRIO_RESET;
            reg_rdata <= 8'h00;
            in_low <= 1'b0;
            in_high <= 1'b0;
            irq_req <= 1'b0;
            irq_src <= ips_pkg::NO_SRC;
            irq_src_high <= 1'b0;
            serial_irq_priority_sel <= 1'b0;
            timer_b_irq_priority_sel <= 1'b0;
            ext_irq_b_priority_sel <= 1'b0;
            timer_a_irq_priority_sel <= 1'b0;
            ext_irq_a_priority_sel <= 1'b0;
        end else begin
            prio <= next_prio;
            reg_rdata <= next_rdata;
            in_low <= next_in_low;
            in_high <= next_in_high;
            irq_req <= next_req;
            irq_src <= next_src;
            irq_src_high <= next_src_high;
            serial_irq_priority_sel <= next_prio[ips_pkg::BIT_SERIAL];
            timer_b_irq_priority_sel <= next_prio[ips_pkg::BIT_TIMER_B];
            ext_irq_b_priority_sel <= next_prio[ips_pkg::BIT_EXT_B];
            timer_a_irq_priority_sel <= next_prio[ips_pkg::BIT_TIMER_A];
            ext_irq_a_priority_sel <= next_prio[ips_pkg::BIT_EXT_A];
        end
    end

    sequence s_write_prio;
        reg_wr && reg_addr == ips_pkg::PRIO_ADDR;
    endsequence

    sequence s_read_prio;
        reg_rd && !reg_wr && reg_addr == ips_pkg::PRIO_ADDR;
    endsequence

    sequence s_read_stat;
        reg_rd && !reg_wr && reg_addr == ips_pkg::STAT_ADDR;
    endsequence

    // Ack only counts while the offer stands
    sequence s_taken;
        irq_ack && irq_req;
    endsequence

    // High request that nothing blocks: no high service, no ack this cycle
    sequence s_high_waiting;
        (irq_pending & prio) != 5'h00 && !in_high && !(irq_ack && irq_req);
    endsequence

    sequence s_low_waiting;
        (irq_pending & ~prio) != 5'h00 && (irq_pending & prio) == 5'h00
            && !in_high && !in_low && !(irq_ack && irq_req);
    endsequence

    AST_SERIAL_BIT: assert property (@(posedge mclk) disable iff (srst)
        s_write_prio |=> serial_irq_priority_sel == $past(reg_wdata[4]))
        else $error("serial priority not taken from bit 4");
    AST_TIMER_B_BIT: assert property (@(posedge mclk) disable iff (srst)
        s_write_prio |=> timer_b_irq_priority_sel == $past(reg_wdata[3]))
        else $error("second timer priority not taken from bit 3");
    AST_EXT_B_BIT: assert property (@(posedge mclk) disable iff (srst)
        s_write_prio |=> ext_irq_b_priority_sel == $past(reg_wdata[2]))
        else $error("second external priority not taken from bit 2");
    AST_TIMER_A_BIT: assert property (@(posedge mclk) disable iff (srst)
        s_write_prio |=> timer_a_irq_priority_sel == $past(reg_wdata[1]))
        else $error("first timer priority not taken from bit 1");
    AST_EXT_A_BIT: assert property (@(posedge mclk) disable iff (srst)
        s_write_prio |=> ext_irq_a_priority_sel == $past(reg_wdata[0]))
        else $error("first external priority not taken from bit 0");
    AST_UPPER_READ: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == ips_pkg::PRIO_ADDR |=> reg_rdata[7:5] == 3'h4)
        else $error("upper priority bits did not read 100");
    AST_READBACK: assert property (@(posedge mclk) disable iff (srst)
        s_write_prio ##1 (reg_rd && reg_addr == ips_pkg::PRIO_ADDR && !reg_wr)
        |=> reg_rdata == {3'h4, $past(reg_wdata[4:0], 2)})
        else $error("priority readback mismatch");
    AST_HIGH_FIRST: assert property (@(posedge mclk) disable iff (srst)
        irq_req && !irq_src_high |-> !$past(|(irq_pending & prio)))
        else $error("low request offered while high pending");
    AST_NO_HIGH_NEST: assert property (@(posedge mclk) disable iff (srst)
        in_high |-> !irq_req)
        else $error("request offered during high service");

    // Select copies must only move on a write, so the core never sees a glitch
    AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (srst)
        !(reg_wr && reg_addr == ips_pkg::PRIO_ADDR) |=> $stable({serial_irq_priority_sel,
            timer_b_irq_priority_sel, ext_irq_b_priority_sel, timer_a_irq_priority_sel,
            ext_irq_a_priority_sel})) else $error("priority select moved without a write");
    AST_SEL_READ_MATCH: assert property (@(posedge mclk) disable iff (srst)
        s_read_prio |=> reg_rdata[4:0] == {serial_irq_priority_sel, timer_b_irq_priority_sel,
            ext_irq_b_priority_sel, timer_a_irq_priority_sel, ext_irq_a_priority_sel})
        else $error("priority readback disagrees with the select outputs");
    AST_STAT_UPPER: assert property (@(posedge mclk) disable iff (srst)
        s_read_stat |=> reg_rdata[7:2] == 6'h00)
        else $error("status upper bits not zero");
    AST_IDLE_RDATA: assert property (@(posedge mclk) disable iff (srst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED_RDATA: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr != ips_pkg::PRIO_ADDR && reg_addr != ips_pkg::STAT_ADDR
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_SRC_NONE: assert property (@(posedge mclk) disable iff (srst)
        !irq_req |-> irq_src == ips_pkg::NO_SRC && !irq_src_high)
        else $error("source shown with no request");
    AST_SRC_RANGE: assert property (@(posedge mclk) disable iff (srst)
        irq_req |-> irq_src < 3'(ips_pkg::NUM_SRC))
        else $error("offered source index out of range");
    AST_SRC_PENDING: assert property (@(posedge mclk) disable iff (srst)
        irq_req |-> (($past(irq_pending) >> irq_src) & 5'h01) != 5'h00)
        else $error("offered source was not pending");
    AST_SRC_LEVEL: assert property (@(posedge mclk) disable iff (srst)
        irq_req |-> irq_src_high == ((($past(prio) >> irq_src) & 5'h01) != 5'h00))
        else $error("offered level disagrees with the priority bit");
    AST_LOW_ORDER: assert property (@(posedge mclk) disable iff (srst)
        irq_req && !irq_src_high
        |-> ($past(irq_pending & ~prio) & ((5'h01 << irq_src) - 5'h01)) == 5'h00)
        else $error("lower numbered low request passed over");
    AST_HIGH_ORDER: assert property (@(posedge mclk) disable iff (srst)
        irq_req && irq_src_high
        |-> ($past(irq_pending & prio) & ((5'h01 << irq_src) - 5'h01)) == 5'h00)
        else $error("lower numbered high request passed over");
    AST_DROP_AFTER_ACK: assert property (@(posedge mclk) disable iff (srst)
        s_taken |=> !irq_req)
        else $error("request still offered after ack");
    AST_HIGH_OFFERED: assert property (@(posedge mclk) disable iff (srst)
        s_high_waiting |=> irq_req && irq_src_high)
        else $error("unblocked high request not offered");
    AST_LOW_OFFERED: assert property (@(posedge mclk) disable iff (srst)
        s_low_waiting |=> irq_req && !irq_src_high)
        else $error("unblocked low request not offered");
    AST_NO_LOW_NEST: assert property (@(posedge mclk) disable iff (srst)
        in_low |-> !(irq_req && !irq_src_high))
        else $error("low request offered during low service");
    AST_RETURN_HIGH: assert property (@(posedge mclk) disable iff (srst)
        in_high && in_low && irq_return && !(irq_ack && irq_req)
        |=> !in_high && in_low)
        else $error("return did not close the high service first");
    AST_RESET_STATE: assert property (@(posedge mclk)
        srst |=> !irq_req && irq_src == ips_pkg::NO_SRC && reg_rdata == 8'h00
            && {serial_irq_priority_sel, timer_b_irq_priority_sel, ext_irq_b_priority_sel,
            timer_a_irq_priority_sel, ext_irq_a_priority_sel} == ips_pkg::PRIO_RESET)
        else $error("outputs not cleared by reset");
endmodule
`default_nettype wire
